// ### core/wdit_prescaler.sv
`include "wdit_cfg.svh"
module wdit_prescaler (
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic              run_i,
	input  wire wdit_pkg::wdit_cks_t cks_i,
	output logic                   tick_o
);
	import wdit_pkg::*;
	logic [11:0] div_reg;
	logic [11:0] div_next;
	logic        tick_reg;
	logic        tick_next;
	logic [11:0] lim;
	always_comb begin
		case (cks_i)
			3'h0:    lim = `WDIT_DIV_LIM0;
			3'h1:    lim = `WDIT_DIV_LIM1;
			3'h2:    lim = `WDIT_DIV_LIM2;
			3'h3:    lim = `WDIT_DIV_LIM3;
			3'h4:    lim = `WDIT_DIV_LIM4;
			3'h5:    lim = `WDIT_DIV_LIM5;
			3'h6:    lim = `WDIT_DIV_LIM6;
			default: lim = `WDIT_DIV_LIM7;
		endcase
		div_next  = div_reg + 12'h001;
		tick_next = 1'b0;
		if (!run_i) begin
			div_next = 12'h000;
		end else if (div_reg >= lim) begin
			div_next  = 12'h000;
			tick_next = 1'b1;
		end
	end
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			div_reg  <= 12'd0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end
	assign tick_o = tick_reg;
endmodule : wdit_prescaler

// ### core/wdit_top.sv
// Design decision made here: the strobed register port.
`include "wdit_cfg.svh"
module wdit_top (
	input  wire logic                     clock_i,
	input  wire logic                     rst_i,
	input  wire logic [`WDIT_ADDR_W-1:0]  addr_i,
	input  wire logic [7:0]               wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	input  wire logic                     ext_reset_pin_i,
	output logic      [7:0]               rdata_o,
	output logic                          interval_irq_o,
	output logic                          internal_reset_o,
	output logic                          reset_out_o,
	output logic                          irq_o
);
	import wdit_pkg::*;
	logic        pin_s1_reg;
	logic        pin_s2_reg;
	wdit_byte_t  tcs_reg;
	wdit_byte_t  tcs_next;
	wdit_byte_t  cnt_reg;
	wdit_byte_t  cnt_next;
	logic        watchdog_reset_flag_reg;
	logic        watchdog_reset_flag_next;
	logic        reset_output_enable_reg;
	logic        reset_output_enable_next;
	logic        ovf_seen_reg;
	logic        ovf_seen_next;
	logic [1:0]  istat_reg;
	logic [1:0]  istat_next;
	logic [1:0]  imask_reg;
	logic [1:0]  imask_next;
	wdit_byte_t  rdata_next;
	logic        iirq_next;
	logic        irq_next;
	wdit_state_t st_reg;
	wdit_state_t st_next;
	wdit_byte_t  pulse_reg;
	wdit_byte_t  pulse_next;
	logic        rst_out_next;
	logic        iout_next;
	logic        rout_next;
	logic        tick;
	logic        wrap;
	logic        timer_enable_bit;
	logic        wd_mode;

	assign timer_enable_bit     = tcs_reg[`WDIT_TME_BIT];
	assign wd_mode = tcs_reg[`WDIT_MODE_BIT];

	wdit_prescaler u_pre (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.run_i   (timer_enable_bit),
		.cks_i   (tcs_reg[2:0]),
		.tick_o  (tick)
	);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg <= ext_reset_pin_i;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign wrap = timer_enable_bit && tick && (cnt_reg == 8'hff);

	always_comb begin
		tcs_next      = tcs_reg;
		cnt_next      = cnt_reg;
		watchdog_reset_flag_next     = watchdog_reset_flag_reg;
		reset_output_enable_next    = reset_output_enable_reg;
		ovf_seen_next = ovf_seen_reg;
		istat_next    = istat_reg;
		imask_next    = imask_reg;
		rdata_next    = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`WDIT_TCS_ADDR: begin
					rdata_next = tcs_reg | `WDIT_TCS_RSV;
					if (tcs_reg[`WDIT_OVF_BIT])
						ovf_seen_next = 1'b1;
				end
				`WDIT_CNT_ADDR:    rdata_next = cnt_reg;
				`WDIT_RCS_RD_ADDR: rdata_next = {watchdog_reset_flag_reg, reset_output_enable_reg, 6'h00} | `WDIT_RCS_RSV;
				`WDIT_ISTAT_ADDR: begin
					rdata_next = {6'h00, istat_reg};
					istat_next = 2'b00;
				end
				`WDIT_IMASK_ADDR:  rdata_next = {6'h00, imask_reg};
				default:           rdata_next = 8'h00;
			endcase
		end
		if (wr_i) begin
			case (addr_i)
				`WDIT_TCS_ADDR: begin
					tcs_next[6:0] = {wdata_i[6:5], 2'b00, wdata_i[2:0]};
					if (!wdata_i[`WDIT_OVF_BIT] && ovf_seen_reg) begin
						tcs_next[`WDIT_OVF_BIT] = 1'b0;
						ovf_seen_next           = 1'b0;
					end
				end
				`WDIT_CNT_ADDR: cnt_next = wdata_i;
				`WDIT_RCS_WR_ADDR: begin
					reset_output_enable_next = wdata_i[`WDIT_RESET_OUTPUT_ENABLE_BIT];
					if (!wdata_i[`WDIT_WATCHDOG_RESET_FLAG_BIT])
						watchdog_reset_flag_next = 1'b0;
				end
				`WDIT_IMASK_ADDR: imask_next = wdata_i[1:0];
				default: ;
			endcase
		end
		if (pin_s2_reg)
			watchdog_reset_flag_next = 1'b0;
		if (!tcs_next[`WDIT_TME_BIT])
			cnt_next = 8'h00;
		else if (timer_enable_bit && tick)
			cnt_next = cnt_reg + 8'h01;
		if (wrap) begin
			tcs_next[`WDIT_OVF_BIT] = 1'b1;
			istat_next[`WDIT_IRQ_OVF_BIT] = 1'b1;
			if (wd_mode) begin
				watchdog_reset_flag_next = 1'b1;
				istat_next[`WDIT_IRQ_WDR_BIT] = 1'b1;
			end
		end
		tcs_next = tcs_next | `WDIT_TCS_RSV;
	end

	always_comb begin
		st_next      = st_reg;
		pulse_next   = pulse_reg;
		case (st_reg)
			WDIT_IDLE: begin
				if (wrap && wd_mode) begin
					st_next    = WDIT_RESET;
					pulse_next = `WDIT_RST_PULSE;
				end
			end
			WDIT_RESET: begin
				pulse_next = pulse_reg - 8'h01;
				if (pulse_reg == 8'h01)
					st_next = WDIT_IDLE;
			end
			default: st_next = WDIT_IDLE;
		endcase
		rst_out_next = (st_next == WDIT_RESET);
		iout_next    = tcs_next[`WDIT_TME_BIT] && !tcs_next[`WDIT_MODE_BIT] && tcs_next[`WDIT_OVF_BIT];
		irq_next     = |(istat_next & imask_next);
		iirq_next    = iout_next;
		rout_next    = rst_out_next && reset_output_enable_next;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tcs_reg      <= `WDIT_TCS_RSV;
			cnt_reg      <= 8'h00;
			watchdog_reset_flag_reg     <= 1'b0;
			reset_output_enable_reg    <= 1'b0;
			ovf_seen_reg <= 1'b0;
			istat_reg    <= 2'b00;
			imask_reg    <= 2'b00;
			rdata_o      <= 8'h00;
		end else begin
			tcs_reg      <= tcs_next;
			cnt_reg      <= cnt_next;
			watchdog_reset_flag_reg     <= watchdog_reset_flag_next;
			reset_output_enable_reg    <= reset_output_enable_next;
			ovf_seen_reg <= ovf_seen_next;
			istat_reg    <= istat_next;
			imask_reg    <= imask_next;
			rdata_o      <= rdata_next;
		end
	end

	// reset sequencer and the interrupt and reset outputs
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_reg           <= WDIT_IDLE;
			pulse_reg        <= 8'h00;
			interval_irq_o   <= 1'b0;
			internal_reset_o <= 1'b0;
			reset_out_o      <= 1'b0;
			irq_o            <= 1'b0;
		end else begin
			st_reg           <= st_next;
			pulse_reg        <= pulse_next;
			interval_irq_o   <= iirq_next;
			internal_reset_o <= rst_out_next;
			reset_out_o      <= rout_next;
			irq_o            <= irq_next;
		end
	end

	count_held_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!timer_enable_bit |=> cnt_reg == 8'h00) else $error("count moved while disabled");
	ovf_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wrap |=> tcs_reg[7]) else $error("overflow not flagged");
	ovf_write1_a: assert property (@(posedge clock_i) disable iff (rst_i) wr_i && addr_i == `WDIT_TCS_ADDR
		&& wdata_i[`WDIT_OVF_BIT] && tcs_reg[`WDIT_OVF_BIT] |=> tcs_reg[`WDIT_OVF_BIT]) else $error("write 1 cleared ovf");
	watchdog_reset_flag_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wrap && wd_mode |=> watchdog_reset_flag_reg) else $error("watchdog flag not set");
	watchdog_reset_flag_pin_a: assert property (@(posedge clock_i) disable iff (rst_i)
		pin_s2_reg && !wrap |=> !watchdog_reset_flag_reg) else $error("pin did not clear flag");
	rcs_read_a: assert property (@(posedge clock_i) disable iff (rst_i) rd_i && addr_i == `WDIT_RCS_RD_ADDR
		|=> rdata_o == {$past(watchdog_reset_flag_reg), $past(reset_output_enable_reg), 6'h3f}) else $error("bad read");
	watchdog_reset_flag_write1_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!watchdog_reset_flag_reg && !wrap |=> !watchdog_reset_flag_reg) else $error("flag set without overflow");
	reset_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
		wrap && wd_mode && st_reg == WDIT_IDLE |=> internal_reset_o [*4] ##1 !internal_reset_o)
		else $error("reset pulse length wrong");
	cnt_step_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		timer_enable_bit && tick && !wr_i |=> cnt_reg == $past(cnt_reg) + 8'h01)
		else $error("count did not advance on tick");
	cnt_still_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		timer_enable_bit && !tick && !wr_i |=> cnt_reg == $past(cnt_reg))
		else $error("count moved without tick");
	tick_stop_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		!timer_enable_bit |=> !tick)
		else $error("prescaler ticked while disabled");
	cnt_read_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `WDIT_CNT_ADDR |=> rdata_o == $past(cnt_reg))
		else $error("count read wrong");
	ovf_noset_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		!tcs_reg[`WDIT_OVF_BIT] && !wrap |=> !tcs_reg[`WDIT_OVF_BIT])
		else $error("overflow flag set without wrap");
	ovf_read_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `WDIT_TCS_ADDR |=> rdata_o[`WDIT_OVF_BIT] == $past(tcs_reg[`WDIT_OVF_BIT]))
		else $error("overflow flag read wrong");
	istat_set_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		wrap |=> istat_reg[`WDIT_IRQ_OVF_BIT])
		else $error("overflow status not set");
	istat_clear_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `WDIT_ISTAT_ADDR && !wrap |=> istat_reg == 2'b00)
		else $error("status not cleared by read");
	irq_level_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		irq_o == |(istat_reg & imask_reg))
		else $error("interrupt level wrong");
	ovf_keep_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		tcs_reg[`WDIT_OVF_BIT] && !(wr_i && addr_i == `WDIT_TCS_ADDR) |=> tcs_reg[`WDIT_OVF_BIT])
		else $error("overflow flag lost");
	ovf_clear_a: assert property (
		@(posedge clock_i) disable iff (rst_i) wr_i && addr_i == `WDIT_TCS_ADDR && !wdata_i[`WDIT_OVF_BIT]
		&& ovf_seen_reg && !wrap |=> !tcs_reg[`WDIT_OVF_BIT])
		else $error("overflow flag not cleared");
	ovf_unread_a: assert property (
		@(posedge clock_i) disable iff (rst_i) wr_i && addr_i == `WDIT_TCS_ADDR
		&& !ovf_seen_reg && tcs_reg[`WDIT_OVF_BIT] |=> tcs_reg[`WDIT_OVF_BIT])
		else $error("overflow cleared without read");
	istat_wdr_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		wrap && wd_mode |=> istat_reg[`WDIT_IRQ_WDR_BIT])
		else $error("watchdog status not set");
	watchdog_reset_flag_write0_a: assert property (
		@(posedge clock_i) disable iff (rst_i) wr_i && addr_i == `WDIT_RCS_WR_ADDR
		&& !wdata_i[`WDIT_WATCHDOG_RESET_FLAG_BIT] && !wrap |=> !watchdog_reset_flag_reg)
		else $error("written 0 did not clear flag");
	reset_output_enable_write_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		wr_i && addr_i == `WDIT_RCS_WR_ADDR |=> reset_output_enable_reg == $past(wdata_i[`WDIT_RESET_OUTPUT_ENABLE_BIT]))
		else $error("reset output enable not written");
	rcs_rdonly_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		wr_i && addr_i == `WDIT_RCS_RD_ADDR |=> reset_output_enable_reg == $past(reset_output_enable_reg))
		else $error("write at read address took effect");
	rdata_idle_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data without read");
	watchdog_reset_flag_hold_a: assert property (
		@(posedge clock_i) disable iff (rst_i) watchdog_reset_flag_reg && !pin_s2_reg
		&& !(wr_i && addr_i == `WDIT_RCS_WR_ADDR && !wdata_i[`WDIT_WATCHDOG_RESET_FLAG_BIT]) |=> watchdog_reset_flag_reg)
		else $error("watchdog flag lost");
	iirq_level_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		interval_irq_o == (timer_enable_bit && !wd_mode && tcs_reg[`WDIT_OVF_BIT]))
		else $error("interval request level wrong");
	iv_noreset_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		wrap && !wd_mode && st_reg == WDIT_IDLE |=> !internal_reset_o)
		else $error("interval overflow caused reset");
	rst_quiet_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		!internal_reset_o && !(wrap && wd_mode) |=> !internal_reset_o)
		else $error("reset without watchdog overflow");
	rstout_gate_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		reset_out_o |-> internal_reset_o && reset_output_enable_reg)
		else $error("reset driven out while disabled");
	rstout_en_a: assert property (
		@(posedge clock_i) disable iff (rst_i)
		internal_reset_o && reset_output_enable_reg |-> reset_out_o)
		else $error("reset not driven out");
endmodule : wdit_top

// ### include/wdit_cfg.svh
`ifndef WDIT_CFG_SVH
`define WDIT_CFG_SVH
`define WDIT_ADDR_W          8
`define WDIT_TCS_ADDR        8'ha8
`define WDIT_CNT_ADDR        8'ha9
`define WDIT_RCS_WR_ADDR     8'haa
`define WDIT_RCS_RD_ADDR     8'hab
`define WDIT_ISTAT_ADDR      8'hac
`define WDIT_IMASK_ADDR      8'had
`define WDIT_OVF_BIT         7
`define WDIT_MODE_BIT        6
`define WDIT_TME_BIT         5
`define WDIT_WATCHDOG_RESET_FLAG_BIT        7
`define WDIT_RESET_OUTPUT_ENABLE_BIT       6
`define WDIT_TCS_RSV         8'h18
`define WDIT_RCS_RSV         8'h3f
`define WDIT_RST_PULSE       8'h04
`define WDIT_DIV_LIM0        12'h001
`define WDIT_DIV_LIM1        12'h01f
`define WDIT_DIV_LIM2        12'h03f
`define WDIT_DIV_LIM3        12'h07f
`define WDIT_DIV_LIM4        12'h0ff
`define WDIT_DIV_LIM5        12'h1ff
`define WDIT_DIV_LIM6        12'h7ff
`define WDIT_DIV_LIM7        12'hfff
`define WDIT_IRQ_OVF_BIT     0
`define WDIT_IRQ_WDR_BIT     1
`endif

// ### include/wdit_pkg.sv
package wdit_pkg;
	typedef logic [7:0] wdit_byte_t;
	typedef logic [2:0] wdit_cks_t;
	typedef enum logic [1:0] {
		WDIT_IDLE  = 2'b00,
		WDIT_RESET = 2'b01
	} wdit_state_t;
endpackage : wdit_pkg

// ### sim/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ext_reset_pin_i = 0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
	logic       interval_irq_o, internal_reset_o, reset_out_o, irq_o;
	int         errors = 0, n_compared = 0, cycles = 0, i;
	int         per [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

	wdit_top dut (
		.clock_i         (clock_i),
		.rst_i           (rst_i),
		.addr_i          (addr_i),
		.wdata_i         (wdata_i),
		.wr_i            (wr_i),
		.rd_i            (rd_i),
		.ext_reset_pin_i (ext_reset_pin_i),
		.rdata_o         (rdata_o),
		.interval_irq_o  (interval_irq_o),
		.internal_reset_o(internal_reset_o),
		.reset_out_o     (reset_out_o),
		.irq_o           (irq_o)
	);

	always #10 clock_i = ~clock_i;

	task test_done;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// whole run is about 27000 cycles, most of it at the slowest clock select
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end

	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk

	task step;
		@(posedge clock_i);
	endtask : step

	task wr(input logic [7:0] a, input logic [7:0] v);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
		@(posedge clock_i);
	endtask : wr

	// read data stand in the cycle after the strobe and are taken at its closing edge
	task rd(input logic [7:0] a);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		@(posedge clock_i);
		d = rdata_o;
	endtask : rd

	task t_reset;
		repeat (20) step();
		rd(8'ha8); chk(d, 8'h18);
		rd(8'hab); chk(d, 8'h3f);
		rd(8'ha9); chk(d, 8'h00);
		$display("reset values done");
	endtask : t_reset

	task t_interval;
		wr(8'had, 8'h01);
		wr(8'ha8, 8'h20);
		for (i = 0; i < 700 && interval_irq_o !== 1'b1; i++) step();
		chk(interval_irq_o, 1'b1);
		chk(irq_o, 1'b1);
		wr(8'had, 8'h00);
		step();
		chk(irq_o, 1'b0);
		wr(8'ha8, 8'h20);
		rd(8'ha8); chk(d, 8'hb8);
		wr(8'ha8, 8'ha0);
		rd(8'ha8); chk(d, 8'hb8);
		wr(8'ha8, 8'h20);
		rd(8'ha8); chk(d, 8'h38);
		rd(8'hac); chk(d, 8'h01);
		rd(8'hac); chk(d, 8'h00);
		chk(interval_irq_o, 1'b0);
		$display("interval mode done");
	endtask : t_interval

	task t_watchdog;
		wr(8'ha8, 8'h00);
		rd(8'ha9); chk(d, 8'h00);
		wr(8'haa, 8'h40);
		wr(8'ha8, 8'h60);
		for (i = 0; i < 700 && internal_reset_o !== 1'b1; i++) step();
		chk(internal_reset_o, 1'b1);
		chk(reset_out_o, 1'b1);
		chk(interval_irq_o, 1'b0);
		rd(8'hab); chk(d, 8'hff);
		rd(8'hac); chk(d, 8'h03);
		wr(8'hab, 8'h00);
		rd(8'hab); chk(d, 8'hff);
		wr(8'haa, 8'hc0);
		rd(8'hab); chk(d, 8'hff);
		wr(8'haa, 8'h40);
		rd(8'hab); chk(d, 8'h7f);
		wr(8'haa, 8'h00);
		for (i = 0; i < 700 && internal_reset_o !== 1'b1; i++) step();
		chk(internal_reset_o, 1'b1);
		chk(reset_out_o, 1'b0);
		rd(8'hab); chk(d, 8'hbf);
		$display("watchdog mode done");
	endtask : t_watchdog

	task t_pin;
		wr(8'ha8, 8'h00);
		ext_reset_pin_i <= 1'b1;
		repeat (4) step();
		ext_reset_pin_i <= 1'b0;
		repeat (4) step();
		rd(8'hab); chk(d, 8'h3f);
		$display("reset pin done");
	endtask : t_pin

	// after three and a half prescaler periods the count must stand at 3, for every clock select
	task t_prescale;
		for (i = 0; i < 8; i++) begin
			wr(8'ha8, 8'h00);
			wr(8'ha8, 8'h20 | i[7:0]);
			repeat (3 * per[i] + per[i] / 2) step();
			rd(8'ha9); chk(d, 8'h03);
		end
		$display("clock select done");
	endtask : t_prescale

	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset();
		t_interval();
		t_watchdog();
		t_pin();
		t_prescale();
		test_done();
	end
endmodule : testbench
